// >>> design/cfg_port.sv
// slave side of the parallel configuration and readback port
// Behaviour
// - while deselected, register no data and leave data and busy undriven
// - select low enables the port, select high disables it
// - with joined selects, every device takes the same data together
// - direction low makes data inputs, direction high makes data outputs
// - direction change while selected starts an abort on next rising edge
// - direction is ignored whenever the port is deselected
// - data drive is asynchronous: on whenever selected and reading
// - writes sample the data lines on each rising config_clock edge
// - reads update the driven data on each rising config_clock edge
// - stopping config_clock pauses loading; loading resumes with new edges
// - busy is never raised while loading, only during readback and during an abort
// - during readback busy low means valid data, high means not valid
// - select held at power-up: busy undriven, then driven low after power-on
// - configuration abort drives an eight-bit status over four clock cycles
// - sampling starts next edge after select; loading starts after sync word
module cfg_port
	import cfg_port_pkg::*;
#(
	parameter int POR_CYCLES_P = POR_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic config_clock,
	input wire port_in_t port_in,
	output port_out_t port_out,
	output logic init_ready,
	output logic sync_seen,
	output logic abort_pulse
);

	localparam int POR_W = $clog2(POR_CYCLES_P + 1);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [DATA_W-1:0] status_word(input logic aligned,
		input logic rip, input logic in_abort_n);
		logic [DATA_W-1:0] w;
		w = {4'h0, ST_FILL};
		w[ST_CFGERR_N] = 1'b1;
		w[ST_ALIGNED] = aligned;
		w[ST_RIP] = rip;
		w[ST_IN_ABORT_N] = in_abort_n;
		return w;
	endfunction

	function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
		return ADDR_W'(a + 1'b1);
	endfunction

	// ****************************************************************
	// power-on timer on ref_clk
	// ****************************************************************
	logic [POR_W-1:0] por_cnt_q;
	logic [POR_W-1:0] por_cnt_d;
	logic por_done_q;
	logic por_done_d;
	logic aln_s1_q;
	logic aln_s2_q;
	logic ab_s1_q;
	logic ab_s2_q;
	logic ab_s3_q;
	logic abort_pulse_q;
	logic abort_pulse_d;
	logic aligned_q;
	logic abort_tgl_q;

	always_comb
	begin
		por_cnt_d = por_cnt_q;
		por_done_d = por_done_q;
		if (!por_done_q)
		begin
			if (por_cnt_q == POR_W'(POR_CYCLES_P - 1))
			begin
				por_done_d = 1'b1;
			end
			else
			begin
				por_cnt_d = POR_W'(por_cnt_q + 1'b1);
			end
		end
		abort_pulse_d = ab_s2_q ^ ab_s3_q;
	end

	// abort events cross as a toggle, the aligned flag as a level
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			por_cnt_q <= '0;
			por_done_q <= 1'b0;
			aln_s1_q <= 1'b0;
			aln_s2_q <= 1'b0;
			ab_s1_q <= 1'b0;
			ab_s2_q <= 1'b0;
			ab_s3_q <= 1'b0;
			abort_pulse_q <= 1'b0;
		end
		else
		begin
			por_cnt_q <= por_cnt_d;
			por_done_q <= por_done_d;
			aln_s1_q <= aligned_q;
			aln_s2_q <= aln_s1_q;
			ab_s1_q <= abort_tgl_q;
			ab_s2_q <= ab_s1_q;
			ab_s3_q <= ab_s2_q;
			abort_pulse_q <= abort_pulse_d;
		end
	end

	assign init_ready = por_done_q;
	assign sync_seen = aln_s2_q;
	assign abort_pulse = abort_pulse_q;

	// ****************************************************************
	// link reset and power-on crossing on config_clock
	// ****************************************************************
	logic [1:0] link_rst_q;
	logic [1:0] link_rst_d;
	logic link_rst;
	logic por_s1_q;
	logic por_s2_q;

	always_comb
	begin
		link_rst_d = {link_rst_q[0], 1'b0};
	end

	// reset asserts at once but releases only on link edges
	always_ff @(posedge config_clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			link_rst_q <= 2'b11;
			por_s1_q <= 1'b0;
			por_s2_q <= 1'b0;
		end
		else
		begin
			link_rst_q <= link_rst_d;
			por_s1_q <= por_done_q;
			por_s2_q <= por_s1_q;
		end
	end

	assign link_rst = link_rst_q[1];

	// ****************************************************************
	// link state machine
	// ****************************************************************
	link_state_t state_q;
	link_state_t state_d;
	logic sel_q;
	logic sel_d;
	logic dir_q;
	logic dir_d;
	logic aligned_d;
	logic abort_tgl_d;
	logic abort_rb_q;
	logic abort_rb_d;
	logic rip_q;
	logic rip_d;
	logic [1:0] abort_cnt_q;
	logic [1:0] abort_cnt_d;
	logic [1:0] rb_cnt_q;
	logic [1:0] rb_cnt_d;
	logic [SYNC_W-1:0] shift_q;
	logic [SYNC_W-1:0] shift_d;
	logic [SYNC_W-1:0] shift_in;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [ADDR_W-1:0] wr_addr_d;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [ADDR_W-1:0] rd_addr_d;
	logic [DATA_W-1:0] dout_q;
	logic [DATA_W-1:0] dout_d;
	logic [DATA_W-1:0] mem_rd_data;
	logic busy_q;
	logic busy_d;
	logic wr_en;
	logic sel;
	logic abort_go;

	// the port listens only once power-on has finished
	assign sel = (port_in.select_n == SEL_ON) && por_s2_q;
	assign abort_go = sel && sel_q && (port_in.direction != dir_q)
		&& (state_q != ST_ABORT);
	assign shift_in = {shift_q[SYNC_W-DATA_W-1:0], port_in.data};

	always_comb
	begin
		state_d = state_q;
		sel_d = sel;
		dir_d = dir_q;
		aligned_d = aligned_q;
		abort_tgl_d = abort_tgl_q;
		abort_rb_d = abort_rb_q;
		rip_d = rip_q;
		abort_cnt_d = abort_cnt_q;
		rb_cnt_d = rb_cnt_q;
		shift_d = shift_q;
		wr_addr_d = wr_addr_q;
		rd_addr_d = rd_addr_q;
		dout_d = dout_q;
		busy_d = busy_q;
		wr_en = 1'b0;
		if (sel)
		begin
			dir_d = port_in.direction;
		end
		if (!sel)
		begin
			// deselected edges change nothing but leave a read or a readback abort
			rb_cnt_d = 2'h0;
			if (state_q == ST_READ)
			begin
				state_d = aligned_q ? ST_LOAD : ST_HUNT;
				busy_d = 1'b0;
			end
			else if (state_q == ST_ABORT && abort_rb_q)
			begin
				state_d = ST_HUNT;
				busy_d = 1'b0;
				abort_rb_d = 1'b0;
			end
		end
		else if (abort_go)
		begin
			state_d = ST_ABORT;
			abort_cnt_d = 2'h0;
			abort_rb_d = (state_q == ST_READ);
			rip_d = (state_q == ST_READ);
			abort_tgl_d = ~abort_tgl_q;
			busy_d = 1'b1;
			dout_d = status_word(aligned_q, state_q == ST_READ, 1'b1);
		end
		else
		begin
			case (state_q)
				ST_HUNT:
				begin
					if (port_in.direction == DIR_READ)
					begin
						state_d = ST_READ;
						rd_addr_d = ADDR_RST;
						busy_d = 1'b1;
					end
					else
					begin
						shift_d = shift_in;
						if (shift_in == SYNC_WORD)
						begin
							state_d = ST_LOAD;
							aligned_d = 1'b1;
						end
					end
				end
				ST_LOAD:
				begin
					if (port_in.direction == DIR_READ)
					begin
						state_d = ST_READ;
						rd_addr_d = ADDR_RST;
						busy_d = 1'b1;
					end
					else
					begin
						// no timeout: a stopped clock simply waits
						wr_en = 1'b1;
						wr_addr_d = next_addr(wr_addr_q);
						busy_d = 1'b0;
					end
				end
				ST_READ:
				begin
					rd_addr_d = next_addr(rd_addr_q);
					dout_d = mem_rd_data;
					if (rb_cnt_q != RB_LAT)
					begin
						rb_cnt_d = 2'(rb_cnt_q + 1'b1);
						busy_d = (2'(rb_cnt_q + 1'b1) != RB_LAT);
					end
					else
					begin
						busy_d = 1'b0;
					end
				end
				ST_ABORT:
				begin
					if (!abort_rb_q)
					begin
						dout_d = status_word(aligned_q, rip_q,
							2'(abort_cnt_q + 1'b1) < ABORT_HALF);
						abort_cnt_d = 2'(abort_cnt_q + 1'b1);
						if (abort_cnt_q == ABORT_LAST)
						begin
							// logic resynchronises: hunt for a fresh sync word
							state_d = ST_HUNT;
							aligned_d = 1'b0;
							shift_d = SHIFT_RST;
							wr_addr_d = ADDR_RST;
							rip_d = 1'b0;
							busy_d = 1'b0;
						end
					end
				end
				default:
				begin
					state_d = ST_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge config_clock or posedge link_rst)
	begin
		if (link_rst)
		begin
			state_q <= ST_HUNT;
			sel_q <= 1'b0;
			dir_q <= DIR_WRITE;
			aligned_q <= 1'b0;
			abort_tgl_q <= 1'b0;
			abort_rb_q <= 1'b0;
			rip_q <= 1'b0;
			abort_cnt_q <= 2'h0;
			rb_cnt_q <= 2'h0;
			shift_q <= SHIFT_RST;
			wr_addr_q <= ADDR_RST;
			rd_addr_q <= ADDR_RST;
			dout_q <= DOUT_RST;
			busy_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sel_q <= sel_d;
			dir_q <= dir_d;
			aligned_q <= aligned_d;
			abort_tgl_q <= abort_tgl_d;
			abort_rb_q <= abort_rb_d;
			rip_q <= rip_d;
			abort_cnt_q <= abort_cnt_d;
			rb_cnt_q <= rb_cnt_d;
			shift_q <= shift_d;
			wr_addr_q <= wr_addr_d;
			rd_addr_q <= rd_addr_d;
			dout_q <= dout_d;
			busy_q <= busy_d;
		end
	end

	// ****************************************************************
	// storage
	// ****************************************************************
	cfg_mem u_mem
	(
		.clk(config_clock),
		.rst(link_rst),
		.wr_en(wr_en),
		.wr_addr(wr_addr_q),
		.wr_data(port_in.data),
		.rd_addr(rd_addr_q),
		.rd_data(mem_rd_data)
	);

	// ****************************************************************
	// pin drivers
	// ****************************************************************
	// enables follow the pins without a clock, so the bus is released at once
	assign port_out.data = dout_q;
	assign port_out.data_oe = (port_in.select_n == SEL_ON)
		&& (port_in.direction == DIR_READ);
	assign port_out.busy = busy_q;
	assign port_out.busy_oe = (port_in.select_n == SEL_ON) && por_done_q;

endmodule

// >>> inc/cfg_port_pkg.sv
// constants and carrier types of the parallel configuration port
package cfg_port_pkg;

	// ****************************************************************
	// widths and stream constants
	// ****************************************************************
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int DEPTH = 256;
	localparam int SYNC_W = 32;
	// arbitrary synchronisation pattern, four bytes, first byte most significant
	localparam logic [SYNC_W-1:0] SYNC_WORD = 32'hA5C33C5A;

	// ****************************************************************
	// pin levels
	// ****************************************************************
	localparam logic SEL_ON = 1'b0;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int REF_CLK_MHZ = 10;
	localparam int T_POR_US = 2000;
	localparam int POR_CYCLES = T_POR_US * REF_CLK_MHZ;
	localparam logic [1:0] ABORT_LAST = 2'h3;
	localparam logic [1:0] ABORT_HALF = 2'h2;
	localparam logic [1:0] RB_LAT = 2'h2;

	// ****************************************************************
	// abort status word layout and reset values
	// ****************************************************************
	localparam int ST_CFGERR_N = 7;
	localparam int ST_ALIGNED = 6;
	localparam int ST_RIP = 5;
	localparam int ST_IN_ABORT_N = 4;
	localparam logic [3:0] ST_FILL = 4'hF;
	localparam logic [DATA_W-1:0] DOUT_RST = 8'h00;
	localparam logic [SYNC_W-1:0] SHIFT_RST = 32'h00000000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		ST_HUNT = 2'b00,
		ST_LOAD = 2'b01,
		ST_READ = 2'b10,
		ST_ABORT = 2'b11
	} link_state_t;

	typedef struct packed
	{
		logic select_n;
		logic direction;
		logic [DATA_W-1:0] data;
	} port_in_t;

	typedef struct packed
	{
		logic [DATA_W-1:0] data;
		logic data_oe;
		logic busy;
		logic busy_oe;
	} port_out_t;

endpackage

// >>> design/cfg_mem.sv
// configuration storage with a registered read port
module cfg_mem
	import cfg_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read data leaves through a register, one edge after the address
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_data <= DOUT_RST;
		end
		else
		begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

// >>> verification/cfg_port_sva.sv
// port assertions for the parallel configuration port
module cfg_port_sva
	import cfg_port_pkg::*;
#(
	parameter int POR_CYCLES_P = POR_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic config_clock,
	input wire port_in_t port_in,
	input wire port_out_t port_out,
	input wire logic init_ready,
	input wire logic sync_seen,
	input wire logic abort_pulse
);
	// ********
	// link side checks, then one abort pulse check on ref_clk
	// ********
	logic sel;
	logic rd;
	logic wr;
	assign sel = port_in.select_n == SEL_ON;
	assign rd = port_in.direction == DIR_READ;
	assign wr = port_in.direction == DIR_WRITE;
	// abort needs select on the edge before the flip too
	sequence rd_entry;
		!sel ##1 sel && rd;
	endsequence
	sequence cfg_abort;
		sel && wr ##1 sel && rd;
	endsequence
	desel_quiet_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		!sel |-> !port_out.data_oe && !port_out.busy_oe) else $error("driving while deselected");
	read_drive_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		sel && rd |-> port_out.data_oe) else $error("read data not driven");
	write_input_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		wr |-> !port_out.data_oe) else $error("data driven in write");
	write_busy_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		!sel ##1 (sel && wr) [*2] |-> !port_out.busy) else $error("busy during load");
	read_wait_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		rd_entry |=> port_out.busy) else $error("busy low too early");
	read_valid_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		rd_entry ##1 (sel && rd) [*3] |-> !port_out.busy) else $error("read data late");
	abort_status_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		cfg_abort |=> port_out.busy && port_out.data[ST_IN_ABORT_N] && port_out.data[3:0] == ST_FILL)
		else $error("abort status wrong");
	abort_flip_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		cfg_abort ##1 (sel && rd) [*2] |=> !port_out.data[ST_IN_ABORT_N])
		else $error("abort flag late");
	rb_abort_a:
		assert property (@(posedge config_clock) disable iff (sys_rst)
		sel && rd ##1 sel && wr |=> port_out.busy) else $error("readback abort missed");
	pulse_single_a:
		assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(abort_pulse) |=> !abort_pulse) else $error("abort pulse too long");
endmodule

bind cfg_port cfg_port_sva #(.POR_CYCLES_P(POR_CYCLES_P)) i_cfg_port_sva
(
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.config_clock(config_clock),
	.port_in(port_in),
	.port_out(port_out),
	.init_ready(init_ready),
	.sync_seen(sync_seen),
	.abort_pulse(abort_pulse)
);

// >>> verification/cfg_ctrl_model.sv
// behavioural configuration controller on the link side
module cfg_ctrl_model
	import cfg_port_pkg::*;
(
	output logic config_clock,
	output port_in_t port_in,
	input wire port_out_t port_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// link driver
	// ********
	initial
	begin
		config_clock = 1'b0;
		port_in = '{1'b1, DIR_WRITE, 8'h00};
	end
	// pins move only while the clock is low; released data toggles so no stale byte lingers
	task automatic drive(input logic sel_n, input logic dir, input logic [DATA_W-1:0] d);
		port_in.select_n = sel_n;
		port_in.direction = dir;
		port_in.data = (sel_n || dir) ? ~port_in.data : d;
	endtask
	// one 48 ns period; the clock rests low between calls, which pauses loading
	task automatic cyc(input logic sel_n, input logic dir, input logic [DATA_W-1:0] d);
		drive(sel_n, dir, d);
		#24 config_clock = 1'b1;
		#24 config_clock = 1'b0;
	endtask
endmodule

// >>> verification/cfg_port_test.sv
// self-checking bench for the parallel configuration port
module cfg_port_test
	import cfg_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic sys_rst;
	logic config_clock;
	port_in_t port_in;
	port_out_t port_out;
	logic init_ready;
	logic sync_seen;
	logic abort_pulse;
	int err_total;
	int n_compared;
	int n_abort;
	int abort_mark;
	int seed;
	int k;
	logic [DATA_W-1:0] img [0:7];

	// ********
	// instances and helpers
	// ********
	cfg_port #(.POR_CYCLES_P(20)) i_cfg_port
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.config_clock(config_clock),
		.port_in(port_in),
		.port_out(port_out),
		.init_ready(init_ready),
		.sync_seen(sync_seen),
		.abort_pulse(abort_pulse)
	);
	cfg_ctrl_model i_cfg_ctrl_model
	(
		.config_clock(config_clock),
		.port_in(port_in),
		.port_out(port_out)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk)
		if (abort_pulse === 1'b1)
			n_abort++;
	function automatic logic [DATA_W-1:0] status(input logic aligned, input logic in_abort_n);
		return {1'b1, aligned, 1'b0, in_abort_n, ST_FILL};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic step(input logic sel_n, input logic dir, input logic [DATA_W-1:0] d);
		i_cfg_ctrl_model.cyc(sel_n, dir, d);
	endtask
	task automatic send_sync(input int n);
		for (int b = 0; b < n; b++)
			step(1'b0, DIR_WRITE, SYNC_WORD[SYNC_W-1-DATA_W*b -: DATA_W]);
	endtask

	// ********
	// scenarios
	// ********
	initial
	begin
		err_total = 0;
		n_compared = 0;
		abort_mark = 0;
		seed = 32'h10FFEA2D;
		sys_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		#7;
		step(1'b1, DIR_WRITE, 8'h00);
		step(1'b1, DIR_WRITE, 8'h00);
		// select held low while power-on runs: busy must stay undriven
		i_cfg_ctrl_model.drive(1'b0, DIR_WRITE, 8'h00);
		#5;
		check("busy oe in por", port_out.busy_oe, 1'b0);
		for (k = 0; k < 200 && init_ready !== 1'b1; k++)
			@(negedge ref_clk);
		// a timeout is counted here and the run still reaches the report
		check("init_ready", init_ready, 1'b1);
		check("busy after por", {port_out.busy_oe, port_out.busy}, 2'b10);
		// direction wanders while deselected: no drive, no abort
		for (k = 0; k < 4; k++)
		begin
			step(1'b1, 1'(k), 8'h00);
			check("desel oe", {port_out.data_oe, port_out.busy_oe}, 2'b00);
		end
		$display("idle test done");
		i_cfg_ctrl_model.drive(1'b0, DIR_WRITE, 8'h00);
		#5;
		check("busy on select", {port_out.busy_oe, port_out.busy}, 2'b10);
		send_sync(3);
		#500;
		check("sync early", sync_seen, 1'b0);
		step(1'b0, DIR_WRITE, SYNC_WORD[DATA_W-1:0]);
		step(1'b1, DIR_WRITE, 8'h00);
		for (k = 0; k < 8; k++)
		begin
			img[k] = 8'($random(seed));
			step(1'b0, DIR_WRITE, img[k]);
			check("load pins", {port_out.busy, port_out.busy_oe, port_out.data_oe}, 3'b010);
		end
		check("sync seen", sync_seen, 1'b1);
		$display("write test done");
		step(1'b1, DIR_WRITE, 8'h00);
		step(1'b1, DIR_READ, 8'h00);
		i_cfg_ctrl_model.drive(1'b0, DIR_READ, 8'h00);
		#5;
		check("read oe", port_out.data_oe, 1'b1);
		for (k = 0; k < 10; k++)
		begin
			step(1'b0, DIR_READ, 8'h00);
			check("read busy", port_out.busy, k < 2);
			if (k >= 2)
				check("read data", port_out.data, img[k-2]);
		end
		check("no abort yet", n_abort, 0);
		step(1'b0, DIR_WRITE, 8'h00);
		check("rb abort busy", port_out.busy, 1'b1);
		step(1'b1, DIR_WRITE, 8'h00);
		check("desel busy oe", port_out.busy_oe, 1'b0);
		$display("read test done");
		repeat (5) @(negedge ref_clk);
		check("rb abort pulse", n_abort, 1);
		abort_mark = n_abort;
		send_sync(4);
		step(1'b0, DIR_WRITE, img[0]);
		for (k = 0; k < 5; k++)
		begin
			step(1'b0, DIR_READ, 8'h00);
			check("abort busy", port_out.busy, k < 4);
			if (k < 4)
				check("abort status", port_out.data, status(1'b1, k < 2));
		end
		step(1'b1, DIR_WRITE, 8'h00);
		repeat (5) @(negedge ref_clk);
		check("abort pulse", n_abort - abort_mark, 1);
		check("aligned cleared", sync_seen, 1'b0);
		$display("abort test done");
		final_report();
	end
endmodule
